// ==== design/dvg_params.svh ====
// constants for the data-enable generator and de-skew configuration block
`ifndef DVG_PARAMS_SVH
`define DVG_PARAMS_SVH

// --------------------------------------------------------------------------
// register sub-addresses
// --------------------------------------------------------------------------
`define DVG_SUB_CTL3   8'h0A
`define DVG_SUB_CFG    8'h0B
`define DVG_SUB_RSV0   8'h0C
`define DVG_SUB_RSV1   8'h0D
`define DVG_SUB_RSV2   8'h0E
`define DVG_SUB_DLY    8'h32
`define DVG_SUB_DECTL  8'h33
`define DVG_SUB_TOP    8'h34
`define DVG_SUB_WID_L  8'h36
`define DVG_SUB_WID_H  8'h37
`define DVG_SUB_HGT_L  8'h38
`define DVG_SUB_HGT_H  8'h39
`define DVG_SUB_HP_L   8'h3A
`define DVG_SUB_HP_H   8'h3B

// --------------------------------------------------------------------------
// reset values and field positions
// --------------------------------------------------------------------------
`define DVG_RST_CTL3   8'h80
`define DVG_RST_RSV    24'h97D0A9
`define DVG_RST_BYTE   8'h00
`define DVG_RST_11     11'h000
`define DVG_SKEW_MSB   7
`define DVG_SKEW_LSB   5
`define DVG_SKEW_EN    4
`define DVG_CTL_MSB    2
`define DVG_CTL_LSB    1
`define DVG_GEN_EN     6
`define DVG_VPOL       5
`define DVG_HPOL       4
`define DVG_DLY8       0

// --------------------------------------------------------------------------
// counts
// --------------------------------------------------------------------------
`define DVG_SKEW_TAPS    8
`define DVG_SKEW_NEUTRAL 3'h4
`define DVG_CNT_MAX      11'h7FF
`define DVG_I2C_ADDR     7'h2C
`define DVG_BITS_BYTE    4'h8

`endif

// ==== design/dvg_pkg.sv ====
// types shared by the generator block and its serial register port
package dvg_pkg;
  typedef enum {st_idle, st_rx, st_ack, st_tx, st_mack} dvg_i2c_state_t;
  typedef enum {kind_addr, kind_sub, kind_data} dvg_byte_kind_t;
  typedef logic [7:0] dvg_byte_t;
endpackage : dvg_pkg

// ==== design/dvg_reg_if.sv ====
// register access link between the serial slave and the register file
`timescale 1ns/10ps
interface dvg_reg_if;
  dvg_pkg::dvg_byte_t addr;
  dvg_pkg::dvg_byte_t wdata;
  logic               wr_stb;
  dvg_pkg::dvg_byte_t rdata;
  modport bus_side (output addr, output wdata, output wr_stb, input rdata);
  modport reg_side (input addr, input wdata, input wr_stb, output rdata);
endinterface : dvg_reg_if

// ==== design/dvg_i2c_slave.sv ====
// serial two-wire register slave with auto-incrementing sub-address
`timescale 1ns/10ps
`include "dvg_params.svh"
module dvg_i2c_slave (
  input  wire logic   clk_sys,
  input  wire logic   resetn,
  input  wire logic   scl_in,
  input  wire logic   sda_in,
  output logic        sda_out,
  output logic        sda_oe_n,
  dvg_reg_if.bus_side regs
);

  // --------------------------------------------------------------------------
  // pin synchronisers and line events
  // --------------------------------------------------------------------------
  logic [1:0]                  scl_sy;
  logic [1:0]                  sda_sy;
  logic                        scl_d;
  logic                        sda_d;
  logic                        start_c;
  logic                        stop_c;
  logic                        rise;
  logic                        fall;
  dvg_pkg::dvg_i2c_state_t     state;
  dvg_pkg::dvg_byte_kind_t     kind;
  logic                        rw;
  logic                        nack;
  logic [3:0]                  cnt;
  dvg_pkg::dvg_byte_t          sr;
  dvg_pkg::dvg_byte_t          ptr;
  dvg_pkg::dvg_byte_t          wdata;
  logic                        wr_stb;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      scl_sy <= 2'h3;
      sda_sy <= 2'h3;
      scl_d  <= 1'h1;
      sda_d  <= 1'h1;
    end else begin
      scl_sy <= {scl_sy[0], scl_in};
      sda_sy <= {sda_sy[0], sda_in};
      scl_d  <= scl_sy[1];
      sda_d  <= sda_sy[1];
    end
  end

  assign start_c = scl_sy[1] & scl_d & sda_d & ~sda_sy[1];
  assign stop_c  = scl_sy[1] & scl_d & ~sda_d & sda_sy[1];
  assign rise    = scl_sy[1] & ~scl_d;
  assign fall    = ~scl_sy[1] & scl_d;

  assign regs.addr   = ptr;
  assign regs.wdata  = wdata;
  assign regs.wr_stb = wr_stb;

  // --------------------------------------------------------------------------
  // byte engine
  // --------------------------------------------------------------------------
  // sda only changes on a seen scl fall, a few cycles late, well inside hold
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state    <= dvg_pkg::st_idle;
      kind     <= dvg_pkg::kind_addr;
      rw       <= 1'h0;
      nack     <= 1'h1;
      cnt      <= 4'h0;
      sr       <= 8'h00;
      ptr      <= 8'h00;
      wdata    <= 8'h00;
      wr_stb   <= 1'h0;
      sda_out  <= 1'h0;
      sda_oe_n <= 1'h1;
    end else begin
      wr_stb <= 1'h0;
      if (wr_stb) begin
        ptr <= ptr + 8'h01;
      end
      if (start_c) begin
        state    <= dvg_pkg::st_rx;
        kind     <= dvg_pkg::kind_addr;
        cnt      <= 4'h0;
        sda_oe_n <= 1'h1;
      end else if (stop_c) begin
        state    <= dvg_pkg::st_idle;
        sda_oe_n <= 1'h1;
      end else begin
        case (state)
          dvg_pkg::st_idle: begin
          end
          dvg_pkg::st_rx: begin
            if (rise) begin
              sr  <= {sr[6:0], sda_sy[1]};
              cnt <= cnt + 4'h1;
            end else if (fall && cnt == `DVG_BITS_BYTE) begin
              cnt <= 4'h0;
              case (kind)
                dvg_pkg::kind_addr: begin
                  if (sr[7:1] == `DVG_I2C_ADDR) begin
                    rw       <= sr[0];
                    sda_oe_n <= 1'h0;
                    state    <= dvg_pkg::st_ack;
                  end else begin
                    state <= dvg_pkg::st_idle;
                  end
                end
                dvg_pkg::kind_sub: begin
                  ptr      <= sr;
                  sda_oe_n <= 1'h0;
                  state    <= dvg_pkg::st_ack;
                end
                default: begin
                  wr_stb   <= 1'h1;
                  wdata    <= sr;
                  sda_oe_n <= 1'h0;
                  state    <= dvg_pkg::st_ack;
                end
              endcase
            end
          end
          dvg_pkg::st_ack: begin
            if (fall) begin
              cnt <= 4'h0;
              if (rw && kind == dvg_pkg::kind_addr) begin
                sr       <= regs.rdata;
                sda_oe_n <= regs.rdata[7];
                state    <= dvg_pkg::st_tx;
              end else begin
                sda_oe_n <= 1'h1;
                state    <= dvg_pkg::st_rx;
                kind     <= (kind == dvg_pkg::kind_addr) ? dvg_pkg::kind_sub
                                                         : dvg_pkg::kind_data;
              end
            end
          end
          dvg_pkg::st_tx: begin
            if (rise) begin
              cnt <= cnt + 4'h1;
            end else if (fall) begin
              if (cnt == `DVG_BITS_BYTE) begin
                sda_oe_n <= 1'h1;
                ptr      <= ptr + 8'h01;
                state    <= dvg_pkg::st_mack;
              end else begin
                sr       <= {sr[6:0], 1'h0};
                sda_oe_n <= sr[6];
              end
            end
          end
          dvg_pkg::st_mack: begin
            if (rise) begin
              nack <= sda_sy[1];
            end else if (fall) begin
              cnt <= 4'h0;
              if (nack) begin
                state <= dvg_pkg::st_idle;
              end else begin
                sr       <= regs.rdata;
                sda_oe_n <= regs.rdata[7];
                state    <= dvg_pkg::st_tx;
              end
            end
          end
          default: begin
            state <= dvg_pkg::st_idle;
          end
        endcase
      end
    end
  end

endmodule : dvg_i2c_slave

// ==== design/dvg_top.sv ====
// data-enable generator, de-skew, blanking control and line period measurement
`timescale 1ns/10ps
`include "dvg_params.svh"
module dvg_top (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  input  wire logic        pix_clk,
  input  wire logic [23:0] pix_data,
  input  wire logic        pix_hsync,
  input  wire logic        pix_vsync,
  input  wire logic        pix_de,
  output logic [23:0]      tx_data,
  output logic             tx_hsync,
  output logic             tx_vsync,
  output logic             tx_de,
  output logic [1:0]       tx_ctl,
  output logic             tx_valid
);

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [10:0] dvg_inc_sat(input logic [10:0] v);
    dvg_inc_sat = (v == `DVG_CNT_MAX) ? v : v + 11'h001;
  endfunction : dvg_inc_sat

  function automatic logic dvg_active(input logic lvl, input logic pol);
    dvg_active = ~(lvl ^ pol);
  endfunction : dvg_active

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  dvg_reg_if regs ();

  dvg_pkg::dvg_byte_t ctl3;
  logic [23:0]        rsvd;
  dvg_pkg::dvg_byte_t dly_lo;
  dvg_pkg::dvg_byte_t de_generator_control;
  dvg_pkg::dvg_byte_t top;
  logic [10:0]        wid;
  logic [10:0]        hgt;
  logic [10:0]        meas;
  dvg_pkg::dvg_byte_t next_rdata;

  logic [27:0]        p_s1;
  logic [27:0]        p_s2;
  logic [26:0]        dline [0:`DVG_SKEW_TAPS-1];
  logic [2:0]         skew_tap;
  logic [26:0]        smp;
  logic               pclk_prev;
  logic               pedge;

  logic               hs_a;
  logic               vs_a;
  logic               hs_prev;
  logic               vs_prev;
  logic               hedge;
  logic               vedge;
  logic               seen_h;
  logic [10:0]        hcount;
  logic [10:0]        vcount;
  logic [10:0]        next_hcount;
  logic [10:0]        next_vcount;
  logic [11:0]        h_lo;
  logic [11:0]        h_hi;
  logic [11:0]        v_lo;
  logic [11:0]        v_hi;
  logic               gen_de;
  logic               next_de;

  // --------------------------------------------------------------------------
  // register port
  // --------------------------------------------------------------------------
  dvg_i2c_slave u_i2c (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_out  (sda_out),
    .sda_oe_n (sda_oe_n),
    .regs     (regs.bus_side)
  );

  // --------------------------------------------------------------------------
  // register file
  // --------------------------------------------------------------------------
  // reserved bytes 0C to 0E are stored as written; software may rely on read-back
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ctl3   <= `DVG_RST_CTL3;
      rsvd   <= `DVG_RST_RSV;
      dly_lo <= `DVG_RST_BYTE;
      de_generator_control <= `DVG_RST_BYTE;
      top    <= `DVG_RST_BYTE;
      wid    <= `DVG_RST_11;
      hgt    <= `DVG_RST_11;
    end else if (regs.wr_stb) begin
      case (regs.addr)
        `DVG_SUB_CTL3:  ctl3 <= regs.wdata;
        `DVG_SUB_RSV0:  rsvd[7:0] <= regs.wdata;
        `DVG_SUB_RSV1:  rsvd[15:8] <= regs.wdata;
        `DVG_SUB_RSV2:  rsvd[23:16] <= regs.wdata;
        `DVG_SUB_DLY:   dly_lo <= regs.wdata;
        `DVG_SUB_DECTL: de_generator_control <= regs.wdata;
        `DVG_SUB_TOP:   top <= regs.wdata;
        `DVG_SUB_WID_L: wid[7:0] <= regs.wdata;
        `DVG_SUB_WID_H: wid[10:8] <= regs.wdata[2:0];
        `DVG_SUB_HGT_L: hgt[7:0] <= regs.wdata;
        `DVG_SUB_HGT_H: hgt[10:8] <= regs.wdata[2:0];
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    case (regs.addr)
      `DVG_SUB_CTL3:  next_rdata = ctl3;
      `DVG_SUB_CFG:   next_rdata = p_s2[23:16];
      `DVG_SUB_RSV0:  next_rdata = rsvd[7:0];
      `DVG_SUB_RSV1:  next_rdata = rsvd[15:8];
      `DVG_SUB_RSV2:  next_rdata = rsvd[23:16];
      `DVG_SUB_DLY:   next_rdata = dly_lo;
      `DVG_SUB_DECTL: next_rdata = de_generator_control;
      `DVG_SUB_TOP:   next_rdata = top;
      `DVG_SUB_WID_L: next_rdata = wid[7:0];
      `DVG_SUB_WID_H: next_rdata = {5'h00, wid[10:8]};
      `DVG_SUB_HGT_L: next_rdata = hgt[7:0];
      `DVG_SUB_HGT_H: next_rdata = {5'h00, hgt[10:8]};
      `DVG_SUB_HP_L:  next_rdata = meas[7:0];
      `DVG_SUB_HP_H:  next_rdata = {5'h00, meas[10:8]};
      default:        next_rdata = 8'h00;
    endcase
  end

  assign regs.rdata = next_rdata;

  // --------------------------------------------------------------------------
  // pixel input sampling and de-skew
  // --------------------------------------------------------------------------
  // every pixel pin goes through two stages before any logic looks at it
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      p_s1      <= 28'h0000000;
      p_s2      <= 28'h0000000;
      pclk_prev <= 1'h0;
    end else begin
      p_s1      <= {pix_clk, pix_hsync, pix_vsync, pix_de, pix_data};
      p_s2      <= p_s1;
      pclk_prev <= p_s2[27];
    end
  end

  // skew step is one system clock; limited to what the sampling rate resolves
  always_ff @(posedge clk_sys) begin
    dline[0] <= p_s2[26:0];
    for (int i = 1; i < `DVG_SKEW_TAPS; i++) begin
      dline[i] <= dline[i-1];
    end
  end

  assign skew_tap = ctl3[`DVG_SKEW_EN] ? ctl3[`DVG_SKEW_MSB:`DVG_SKEW_LSB]
                                       : `DVG_SKEW_NEUTRAL;
  assign smp      = dline[skew_tap];
  assign pedge    = p_s2[27] & ~pclk_prev;

  // --------------------------------------------------------------------------
  // sync edges and counters
  // --------------------------------------------------------------------------
  assign hs_a  = dvg_active(smp[26], de_generator_control[`DVG_HPOL]);
  assign vs_a  = dvg_active(smp[25], de_generator_control[`DVG_VPOL]);
  assign hedge = hs_a & ~hs_prev;
  assign vedge = vs_a & ~vs_prev;

  always_comb begin
    next_hcount = hedge ? 11'h000 : dvg_inc_sat(hcount);
    if (vedge) begin
      next_vcount = 11'h000;
    end else if (hedge) begin
      next_vcount = dvg_inc_sat(vcount);
    end else begin
      next_vcount = vcount;
    end
  end

  // counters start saturated so nothing is generated before the first syncs
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      hs_prev <= 1'h0;
      vs_prev <= 1'h0;
      hcount  <= `DVG_CNT_MAX;
      vcount  <= `DVG_CNT_MAX;
    end else if (pedge) begin
      hs_prev <= hs_a;
      vs_prev <= vs_a;
      hcount  <= next_hcount;
      vcount  <= next_vcount;
    end
  end

  // --------------------------------------------------------------------------
  // line period measurement
  // --------------------------------------------------------------------------
  // the first edge only arms; a partial line would give a false figure
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      seen_h <= 1'h0;
      meas   <= `DVG_RST_11;
    end else if (pedge && hedge) begin
      seen_h <= 1'h1;
      if (seen_h) begin
        meas <= dvg_inc_sat(hcount);
      end
    end
  end

  // --------------------------------------------------------------------------
  // enable generation
  // --------------------------------------------------------------------------
  // sums are twelve bits wide so an over-range setting cannot wrap round
  assign h_lo = {3'h0, de_generator_control[`DVG_DLY8], dly_lo};
  assign h_hi = h_lo + {1'h0, wid};
  assign v_lo = {4'h0, top};
  assign v_hi = v_lo + {1'h0, hgt};

  always_comb begin
    gen_de = ({1'h0, next_vcount} >= v_lo) && ({1'h0, next_vcount} < v_hi)
          && ({1'h0, next_hcount} >= h_lo) && ({1'h0, next_hcount} < h_hi);
    next_de = de_generator_control[`DVG_GEN_EN] ? gen_de : smp[24];
  end

  // --------------------------------------------------------------------------
  // link side outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tx_data  <= 24'h000000;
      tx_hsync <= 1'h0;
      tx_vsync <= 1'h0;
      tx_de    <= 1'h0;
      tx_ctl   <= 2'h0;
      tx_valid <= 1'h0;
    end else begin
      tx_valid <= pedge;
      if (pedge) begin
        tx_data  <= smp[23:0];
        tx_hsync <= smp[26];
        tx_vsync <= smp[25];
        tx_de    <= next_de;
        tx_ctl   <= next_de ? 2'h0 : ctl3[`DVG_CTL_MSB:`DVG_CTL_LSB];
      end
    end
  end

endmodule : dvg_top

// ==== verification/dvg_top_props.sv ====
// assertion checker on the top-level ports of the enable generator block
`timescale 1ns/10ps
module dvg_top_props (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe_n,
  input wire logic        pix_clk,
  input wire logic [23:0] pix_data,
  input wire logic        pix_hsync,
  input wire logic        pix_vsync,
  input wire logic        pix_de,
  input wire logic [23:0] tx_data,
  input wire logic        tx_hsync,
  input wire logic        tx_vsync,
  input wire logic        tx_de,
  input wire logic [1:0]  tx_ctl,
  input wire logic        tx_valid
);
  logic [4:0] idle_cnt;
  logic       pclk_q;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  always_ff @(posedge clk_sys) begin
    pclk_q <= pix_clk;
  end
  // a pixel edge needs well under sixteen cycles to come out
  always_ff @(posedge clk_sys) begin
    if (!resetn || pix_clk != pclk_q) idle_cnt <= 5'h00;
    else if (idle_cnt != 5'h1F) idle_cnt <= idle_cnt + 5'h01;
  end
  // ------------------------------------------------
  // properties
  // ------------------------------------------------
  AST_CTL_ACTIVE: assert property (tx_de |-> tx_ctl == 2'b00)
    else $error("control bits not cleared in active pixels");
  AST_VALID_PULSE: assert property (tx_valid |=> !tx_valid)
    else $error("valid pulse longer than one cycle");
  AST_OUT_HOLD: assert property (!tx_valid |-> $stable({tx_data, tx_hsync, tx_vsync, tx_de, tx_ctl}))
    else $error("link outputs moved without valid");
  AST_EDGE_VALID: assert property ($rose(pix_clk) |-> ##[1:14] tx_valid)
    else $error("pixel edge gave no valid");
  AST_NO_STRAY: assert property (idle_cnt >= 5'h10 |-> !tx_valid)
    else $error("valid without a pixel edge");
  AST_RESET_IDLE: assert property (disable iff (1'b0)
    !resetn |=> !tx_valid && !tx_de && tx_ctl == 2'b00 && sda_oe_n)
    else $error("outputs not idle in reset");
  AST_OPEN_DRAIN: assert property (!sda_oe_n |-> !sda_out)
    else $error("data pin driven high");
  AST_SDA_SCL_LOW: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data pin changed while clock high");
  COV_DE_RISE: cover property ($rose(tx_de));
  COV_ACK: cover property (!sda_oe_n);
  COV_CTL_BLANK: cover property (tx_valid && !tx_de && tx_ctl == 2'b11);
endmodule : dvg_top_props

// ==== verification/dvg_pix_src.sv ====
// pixel source standing in for the graphics controller
`timescale 1ns/10ps
module dvg_pix_src #(parameter int HT = 24, parameter int VT = 10) (
  input  wire logic       clk_sys,
  input  wire logic       run,
  input  wire logic       hpol,
  input  wire logic       vpol,
  input  wire logic [7:0] strap,
  output logic            pix_clk,
  output logic [23:0]     pix_data,
  output logic            pix_hsync,
  output logic            pix_vsync,
  output logic            pix_de
);
  logic [3:0] ph;
  int         h;
  int         v;
  initial begin
    {ph, pix_clk, pix_data, pix_hsync, pix_vsync, pix_de} = 32'h0;
    h = 0;
    v = 0;
  end
  // clock stands low between runs, no free-running pixel clock
  always @(posedge clk_sys) begin
    ph <= run ? ph + 4'h1 : 4'h0;
    pix_clk <= run & ~ph[3];
    pix_data[23:16] <= strap;
    if (run && ph == 4'hB) begin
      // fields move five cycles before the rising edge so taps 0..4 and 5..7 split
      pix_data[15:0] <= {v[7:0], h[7:0]};
      pix_hsync <= (h < 2) ? hpol : ~hpol;
      pix_vsync <= (v < 2) ? vpol : ~vpol;
      pix_de <= h >= 2 && h < HT - 2;
      h <= (h == HT - 1) ? 0 : h + 1;
      if (h == HT - 1) v <= (v == VT - 1) ? 0 : v + 1;
    end
  end
endmodule : dvg_pix_src

// ==== verification/dvg_top_bench.sv ====
// self-checking bench for the enable generator and skew configuration
`timescale 1ns/10ps
`include "dvg_params.svh"
module dvg_top_bench;
  localparam int HT = 24;
  localparam int FRM = HT * 10 * 16;
  logic clk_sys = 1'b0;
  logic resetn, scl, sda_m, run, hpol, vpol, chk_on, gen, hs, vs, hs_q, vs_q, ex;
  logic [7:0] strap;
  logic [1:0] ctl;
  int error_cnt = 0, cmp_count = 0, h = 0, v = 0, dly, wid, top, hgt;
  wire sda_out, sda_oe_n, pix_clk, pix_hsync, pix_vsync, pix_de;
  wire tx_hsync, tx_vsync, tx_de, tx_valid;
  wire [23:0] pix_data, tx_data;
  wire [1:0] tx_ctl;
  wire sda_w = sda_m & (sda_oe_n | sda_out);
  always #2 clk_sys = ~clk_sys;
  dvg_top dut_u (
    .clk_sys(clk_sys), .resetn(resetn), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .pix_clk(pix_clk), .pix_data(pix_data), .pix_hsync(pix_hsync),
    .pix_vsync(pix_vsync), .pix_de(pix_de), .tx_data(tx_data), .tx_hsync(tx_hsync),
    .tx_vsync(tx_vsync), .tx_de(tx_de), .tx_ctl(tx_ctl), .tx_valid(tx_valid));
  dvg_pix_src #(.HT(HT), .VT(10)) src_u (
    .clk_sys(clk_sys), .run(run), .hpol(hpol), .vpol(vpol), .strap(strap),
    .pix_clk(pix_clk), .pix_data(pix_data), .pix_hsync(pix_hsync),
    .pix_vsync(pix_vsync), .pix_de(pix_de));
  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  task automatic chk(input logic [63:0] got, exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : chk
  task automatic pins(input logic c, d);
    scl <= c;
    sda_m <= d;
    repeat (16) @(posedge clk_sys);
  endtask : pins
  task automatic ibyte(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    logic [8:0] b;
    b = {d, a};
    for (int i = 8; i >= 0; i--) begin
      pins(1'b0, b[i]);
      pins(1'b1, b[i]);
      if (i > 0) q[i-1] = sda_w;
      else k = sda_w;
      pins(1'b0, b[i]);
    end
  endtask : ibyte
  task automatic istart;
    pins(1'b0, 1'b1);
    pins(1'b1, 1'b1);
    pins(1'b1, 1'b0);
    pins(1'b0, 1'b0);
  endtask : istart
  task automatic wr(input logic [7:0] s, input int n, input logic [63:0] d);
    logic [7:0] q;
    logic k;
    istart();
    ibyte({`DVG_I2C_ADDR, 1'b0}, 1'b1, q, k);
    chk(k, 1'b0, "address ack");
    ibyte(s, 1'b1, q, k);
    for (int i = 0; i < n; i++) ibyte(d[8*i +: 8], 1'b1, q, k);
    pins(1'b0, 1'b0);
    pins(1'b1, 1'b0);
    pins(1'b1, 1'b1);
  endtask : wr
  task automatic rc(input logic [7:0] s, input int n, input logic [63:0] e);
    logic [63:0] d;
    logic [7:0] q;
    logic k;
    d = 64'h0;
    wr(s, 0, 64'h0);
    istart();
    ibyte({`DVG_I2C_ADDR, 1'b1}, 1'b1, q, k);
    for (int i = 0; i < n; i++) begin
      ibyte(8'hFF, i == n - 1, q, k);
      d[8*i +: 8] = q;
    end
    pins(1'b0, 1'b0);
    pins(1'b1, 1'b0);
    pins(1'b1, 1'b1);
    chk(d, e, "register read");
  endtask : rc
  // reference position counters follow the syncs seen on the link
  always @(posedge clk_sys) begin
    if (tx_valid === 1'b1) begin
      hs = tx_hsync === hpol;
      vs = tx_vsync === vpol;
      h = (hs && !hs_q) ? 0 : h + 1;
      if (vs && !vs_q) v = 0;
      else if (hs && !hs_q) v++;
      hs_q = hs;
      vs_q = vs;
      ex = gen ? (h >= dly && h < dly + wid && v >= top && v < top + hgt) : (h >= 2 && h < HT - 2);
      if (chk_on) chk(tx_de, ex, "enable");
      if (chk_on && tx_de === 1'b0) chk(tx_ctl, ctl, "blank ctl");
    end
  end
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_regs;
    rc(8'h0A, 5, 64'h97D0A93C80);
    rc(8'h32, 8, 64'h0);
    strap <= 8'hA5;
    repeat (8) @(posedge clk_sys);
    rc(8'h0B, 1, 64'hA5);
  endtask : t_regs
  task automatic t_skew;
    logic [15:0] s [9];
    logic [7:0] n, d0;
    run <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      wr(8'h0A, 1, (i < 8) ? {i[2:0], 5'h10} : 8'h00);
      @(posedge clk_sys iff pix_clk === 1'b0);
      @(posedge clk_sys iff pix_clk === 1'b1);
      d0 = pix_data[7:0];
      n = 8'h00;
      while (tx_valid !== 1'b1 && n < 8'h28) begin
        n++;
        @(posedge clk_sys);
      end
      s[i] = {n, 7'h00, tx_data[7:0] === d0};
    end
    chk(s[8], s[4], "skew off");
    chk({s[0][0], s[4][0], s[5][0], s[7][0]}, 4'b1100, "skew range");
    chk(tx_data[23:16], 8'hA5, "upper data");
  endtask : t_skew
  task automatic t_gen(input logic g, hq, vq, input int d, w, t, ht, input logic [1:0] c);
    logic [63:0] x;
    chk_on = 1'b0;
    gen = g;
    dly = d;
    wid = w;
    top = t;
    hgt = ht;
    ctl = c;
    hpol <= hq;
    vpol <= vq;
    x = {5'h0, ht[10:8], ht[7:0], 5'h0, w[10:8], w[7:0], 8'h00, t[7:0],
         1'b0, g, vq, hq, 3'h0, d[8], d[7:0]};
    wr(8'h0A, 1, {3'h4, 2'h0, c, 1'b0});
    wr(8'h32, 8, x | 64'hF800F800FF000000);
    rc(8'h32, 8, x);
    chk_on = 1'b1;
    repeat (FRM) @(posedge clk_sys);
    chk_on = 1'b0;
  endtask : t_gen
  task automatic wrap_up;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    {resetn, scl, sda_m, run, hpol, vpol} = 6'h1B;
    strap = 8'h3C;
    {chk_on, gen, hs_q, vs_q, ctl} = 6'h0;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (8) @(posedge clk_sys);
    t_regs();
    t_skew();
    t_gen(1'b1, 1'b1, 1'b1, 3, 5, 2, 4, 2'b01);
    t_gen(1'b1, 1'b0, 1'b0, 20, 4, 0, 9, 2'b10);
    t_gen(1'b1, 1'b1, 1'b0, 259, 2, 1, 2, 2'b11);
    t_gen(1'b0, 1'b0, 1'b1, 3, 5, 2, 4, 2'b00);
    rc(8'h3A, 2, 64'h18);
    wrap_up();
  end
  initial begin
    repeat (95000) @(posedge clk_sys);
    error_cnt++;
    wrap_up();
  end
endmodule : dvg_top_bench
bind dvg_top dvg_top_props u_props (
  .clk_sys(clk_sys), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .pix_clk(pix_clk), .pix_data(pix_data), .pix_hsync(pix_hsync),
  .pix_vsync(pix_vsync), .pix_de(pix_de), .tx_data(tx_data), .tx_hsync(tx_hsync),
  .tx_vsync(tx_vsync), .tx_de(tx_de), .tx_ctl(tx_ctl), .tx_valid(tx_valid));
